// [cps_pwm.sv]
// The Avalon-MM slave port and the register addresses were decided locally.
`default_nettype none
// ---------------------------------------------------------------
// Standard PWM unit with Avalon-MM register slave
// ---------------------------------------------------------------
// Operation
// - Up to ten bit PWM on pin
// - Period is (limit+1)*4*Tosc*prescale
// - Timer clears after matching period limit
// - Rollover sets pin unless duty zero
// - Rollover copies duty into compare buffer
// - Duty writes take effect next rollover
// - Duty alignment chosen by align bit
// - Time base: count plus two low bits
// - Time base match with duty clears pin
// - Pulse width is duty*Tosc*prescale
// - Postscaler never affects PWM waveform
// - Resolution grows with period limit
// - Duty above period keeps pin high
// - Sleep freezes timer and pin
// - PWM rate follows system clock
// - Reset restores registers, pin input
// - Right aligned: high[1:0], low[7:0]
// - Left aligned: high[7:0], low[7:6]
module cps_pwm
  import cps_pkg::*;
#(
  parameter int unsigned CNT_W = PER_W,  // Timer width
  parameter int unsigned DTY_W = DUTY_W  // Duty width
)(
  input  wire logic        clock_in,          // 50 MHz system clock
  input  wire logic        sys_rst_in,        // Sync reset, high
  input  wire logic        sleep_in,          // Device asleep
  input  wire logic [7:0]  avs_address_in,    // Byte address
  input  wire logic        avs_read_in,       // Read request
  input  wire logic        avs_write_in,      // Write request
  input  wire logic [31:0] avs_writedata_in,  // Write data
  input  wire logic [3:0]  avs_byteenable_in, // Byte lanes
  output logic      [31:0] avs_readdata_out,  // Read data
  output logic             avs_waitrequest_out, // Stall
  output logic             pin_out,           // unit_output_pin level
  output logic             pin_oe_out         // Pin driven when high
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Time base is the count plus two bits; only 8/10 is built
  if (CNT_W != PER_W || DTY_W != CNT_W + 2) begin : g_chk
    $error("cps_pwm supports only an 8-bit timer, 10-bit duty");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cps_ctrl_s   ctrl_ff;      // unit_control_register
  logic [15:0] duty_reg_ff;  // duty_value_register
  logic [7:0]  plim_ff;      // period_limit_register
  logic [7:0]  tctl_ff;      // period_timer_control
  logic [7:0]  tcnt_ff;      // period_timer_count
  logic [3:0]  post_ff;      // Postscaler count
  logic        flag_ff;      // period_timer_flag
  logic [9:0]  duty_buf_ff;  // Compare buffer
  logic        wait_ff;      // Bus stall
  logic [31:0] rdata_ff;     // Read data
  logic        out_ff;       // Pin level
  logic        oe_ff;        // Pin driver enable

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic       req;      // Request present
  logic       acc;      // Request completes this edge
  logic       wr;       // Write completes this edge
  logic       wr_lo;    // Low byte lane written
  logic       wr_hi;    // Second byte lane written
  logic       wr_ctrl;  // Control write
  logic       wr_tcnt;  // Timer count write
  logic [7:0] wd0;      // Write data low byte
  logic [7:0] wd1;      // Write data second byte

  assign req     = avs_read_in || avs_write_in;
  assign acc     = req && !wait_ff;
  assign wr      = acc && avs_write_in;
  assign wr_lo   = wr && avs_byteenable_in[0];
  assign wr_hi   = wr && avs_byteenable_in[1];
  assign wd0     = avs_writedata_in[7:0];
  assign wd1     = avs_writedata_in[15:8];
  assign wr_ctrl = wr_lo && avs_address_in == ADR_CTRL;
  assign wr_tcnt = wr_lo && avs_address_in == ADR_TCNT;

  // ---------------------------------------------------------------
  // Time base and events
  // ---------------------------------------------------------------
  cps_tick_s  tick;     // Prescaler strobes
  logic       pwm_on;   // Unit enabled in PWM mode
  logic       roll;     // Period rollover
  logic [9:0] duty_cur; // Programmed duty, aligned
  logic [9:0] tb;       // 10-bit time base
  logic [9:0] tb_next;  // Time base after next step
  logic       post_hit; // Postscaler terminal count

  // Prescaler only sees the instruction clock, so the period
  // scales with the system clock rate
  cps_tick_gen u_tick (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (tctl_ff[TCT_ON]),
    .hold_in    (sleep_in),
    .psel_in    (cps_ps_e'(tctl_ff[TCT_PS +: 2])),
    .tick_out   (tick)
  );

  assign pwm_on   = ctrl_ff.en && cps_is_pwm(ctrl_ff.mode);
  // Rollover on the increment after the limit match
  assign roll     = tick.inc && tcnt_ff == plim_ff;
  // Alignment select
  assign duty_cur = cps_duty(duty_reg_ff, ctrl_ff.align);
  // Count extended by two low bits
  assign tb       = {tcnt_ff, tick.low2};
  assign tb_next  = tb + 10'h001;
  assign post_hit = post_ff == tctl_ff[TCT_POST +: 4];

  // ---------------------------------------------------------------
  // Avalon slave handshake
  // ---------------------------------------------------------------
  // One stall cycle, then waitrequest low for exactly one cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !(req && wait_ff);
    end
  end

  // Read data captured when the stall ends; unmapped reads zero
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req && wait_ff) begin
      rdata_ff <= 32'h0000_0000;
      unique case (avs_address_in)
        ADR_CTRL: begin
          rdata_ff[CTL_EN]         <= ctrl_ff.en;
          rdata_ff[CTL_OUT]        <= out_ff;
          rdata_ff[CTL_ALN]        <= ctrl_ff.align;
          rdata_ff[CTL_MODE +: 4]  <= ctrl_ff.mode;
        end
        ADR_DUTY: rdata_ff[15:0] <= duty_reg_ff;
        ADR_PLIM: rdata_ff[7:0]  <= plim_ff;
        ADR_TCTL: rdata_ff[7:0]  <= tctl_ff;
        ADR_STAT: rdata_ff[STA_FLAG] <= flag_ff;
        ADR_TCNT: rdata_ff[7:0]  <= tcnt_ff;
        ADR_PDIR: rdata_ff[DIR_BIT]  <= !oe_ff;
        default:  rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Control, reset to disabled
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= '0;
    end else if (wr_ctrl) begin
      ctrl_ff.en    <= wd0[CTL_EN];
      ctrl_ff.align <= wd0[CTL_ALN];
      ctrl_ff.mode  <= wd0[CTL_MODE +: 4];
    end
  end

  // Duty may be written any time; compare uses the buffer
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      duty_reg_ff <= DUTY_RST;
    end else if (avs_address_in == ADR_DUTY) begin
      if (wr_lo) begin
        duty_reg_ff[7:0] <= wd0;
      end
      if (wr_hi) begin
        duty_reg_ff[15:8] <= wd1;
      end
    end
  end

  // Period limit and timer control
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      plim_ff <= PLIM_RST;
      tctl_ff <= TCTL_RST;
    end else if (wr_lo) begin
      if (avs_address_in == ADR_PLIM) begin
        plim_ff <= wd0;
      end
      if (avs_address_in == ADR_TCTL) begin
        tctl_ff <= wd0;
      end
    end
  end

  // Pin driver enable; a set direction bit means input
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      oe_ff <= !DIR_RST;
    end else if (wr_lo && avs_address_in == ADR_PDIR) begin
      oe_ff <= !wd0[DIR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Period timer
  // ---------------------------------------------------------------
  // Software write beats counting; sleep stops it
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tcnt_ff <= 8'h00;
    end else if (wr_tcnt) begin
      tcnt_ff <= wd0;
    end else if (roll) begin
      tcnt_ff <= 8'h00;
    end else if (tick.inc) begin
      tcnt_ff <= tcnt_ff + 8'h01;
    end
  end

  // Postscaler only paces the flag, never the waveform
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !tctl_ff[TCT_ON]) begin
      post_ff <= 4'h0;
    end else if (roll) begin
      post_ff <= post_hit ? 4'h0 : post_ff + 4'h1;
    end
  end

  // Flag: write one clears, a new set wins over the clear
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      flag_ff <= 1'b0;
    end else if (roll && post_hit) begin
      flag_ff <= 1'b1;
    end else if (wr_lo && avs_address_in == ADR_STAT && wd0[STA_FLAG]) begin
      flag_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Duty buffer and output
  // ---------------------------------------------------------------
  // Loaded only at rollover and only in PWM
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      duty_buf_ff <= 10'h000;
    end else if (roll && pwm_on) begin
      duty_buf_ff <= duty_cur;
    end
  end

  // Pin set at rollover, cleared when time base reaches duty
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      out_ff <= 1'b0;
    end else if (!pwm_on) begin
      out_ff <= 1'b0;
    end else if (roll) begin
      out_ff <= duty_cur != 10'h000;
    end else if (tick.step && tb_next == duty_buf_ff) begin
      // High for duty steps of Tosc*prescale
      // A duty past the period never matches
      out_ff <= 1'b0;
    end
  end

  assign avs_waitrequest_out = wait_ff;
  assign avs_readdata_out    = rdata_ff;
  assign pin_out             = out_ff;
  assign pin_oe_out          = oe_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_roll_clear_cnt: assert property (
    roll && !wr_tcnt |=> tcnt_ff == 8'h00)
    else $error("timer not cleared after limit match");

  a_roll_set_pin: assert property (
    roll && pwm_on && !wr_ctrl |=> out_ff == ($past(duty_cur) != 10'h000))
    else $error("pin level wrong at rollover");

  a_buf_load_roll: assert property (
    roll && pwm_on |=> duty_buf_ff == $past(duty_cur))
    else $error("duty buffer not loaded at rollover");

  a_buf_hold_else: assert property (
    !(roll && pwm_on) |=> $stable(duty_buf_ff))
    else $error("duty buffer changed outside rollover");

  a_align_pick: assert property (
    roll && pwm_on && ctrl_ff.align && !wr_lo && !wr_hi
    |=> duty_buf_ff[9:2] == duty_reg_ff[15:8] && duty_buf_ff[1:0] == duty_reg_ff[7:6])
    else $error("left alignment wrong");

  a_match_clear_pin: assert property (
    pwm_on && !roll && tick.step && tb_next == duty_buf_ff && !wr_ctrl
    |=> !out_ff)
    else $error("pin not cleared at duty match");

  a_sleep_hold_all: assert property (
    sleep_in && !wr_tcnt && !wr_ctrl |=> $stable(tcnt_ff) && $stable(out_ff))
    else $error("state moved during sleep");

  a_reset_pin_input: assert property (
    @(posedge clock_in) disable iff (1'b0)
    sys_rst_in |=> !pin_oe_out && !pin_out && !ctrl_ff.en)
    else $error("reset did not release pin");

  a_off_pin_low: assert property (
    !pwm_on |=> !out_ff)
    else $error("pin high while not in PWM");

endmodule
`default_nettype wire

// [cps_pkg.sv]
`default_nettype none
// ---------------------------------------------------------------
// Shared constants and types for the standard PWM unit
// ---------------------------------------------------------------
package cps_pkg;

  // Widths of timer count and duty value
  localparam int unsigned PER_W  = 8;
  localparam int unsigned DUTY_W = 10;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00; // unit_control_register
  localparam logic [7:0] ADR_DUTY = 8'h04; // duty_value_register
  localparam logic [7:0] ADR_PLIM = 8'h08; // period_limit_register
  localparam logic [7:0] ADR_TCTL = 8'h0C; // period_timer_control
  localparam logic [7:0] ADR_STAT = 8'h10; // period_timer_flag
  localparam logic [7:0] ADR_TCNT = 8'h14; // period_timer_count
  localparam logic [7:0] ADR_PDIR = 8'h18; // pin_direction_bit

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTL_EN   = 7; // Unit enable
  localparam int unsigned CTL_OUT  = 5; // Output level, read only
  localparam int unsigned CTL_ALN  = 4; // duty_align_bit
  localparam int unsigned CTL_MODE = 0; // Mode field, 4 bits
  localparam int unsigned TCT_ON   = 7; // Timer run
  localparam int unsigned TCT_PS   = 4; // timer_prescale_select, 2 bits
  localparam int unsigned TCT_POST = 0; // Postscaler, 4 bits
  localparam int unsigned STA_FLAG = 0; // period_timer_flag
  localparam int unsigned DIR_BIT  = 0; // pin_direction_bit

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  PLIM_RST = 8'hFF;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [7:0]  TCTL_RST = 8'h00;
  localparam logic        DIR_RST  = 1'b1; // Input after reset

  // Last system clock phase of one instruction cycle
  localparam logic [1:0] PH_LAST  = 2'h3;
  // Mode codes whose top two bits mark PWM
  localparam logic [1:0] MODE_PWM = 2'h3;

  // Prescale choices 1:1, 1:4, 1:16, 1:64
  typedef enum logic [1:0] {PS_1, PS_4, PS_16, PS_64} cps_ps_e;

  // Unit control fields
  typedef struct packed {
    logic       en;
    logic       align;
    logic [3:0] mode;
  } cps_ctrl_s;

  // Time base strobes from the prescaler
  typedef struct packed {
    logic       step; // Time base advances
    logic       inc;  // Timer count advances
    logic [1:0] low2; // Two low time base bits
  } cps_tick_s;

  // Mode field selects PWM
  function automatic logic cps_is_pwm(input logic [3:0] mode);
    return mode[3:2] == MODE_PWM;
  endfunction

  // Pick the 10-bit duty from the 16-bit register
  function automatic logic [9:0] cps_duty(input logic [15:0] r,
                                          input logic align);
    return align ? {r[15:8], r[7:6]} : {r[9:8], r[7:0]};
  endfunction

endpackage
`default_nettype wire

// [cps_tick_gen.sv]
`default_nettype none
// ---------------------------------------------------------------
// Instruction clock divider and timer prescaler
// ---------------------------------------------------------------
module cps_tick_gen
  import cps_pkg::*;
(
  input  wire logic      clock_in,   // System clock
  input  wire logic      sys_rst_in, // Synchronous reset
  input  wire logic      run_in,     // Timer running
  input  wire logic      hold_in,    // Sleep freeze
  input  wire cps_ps_e   psel_in,    // Prescale choice
  output cps_tick_s      tick_out    // Strobes and low bits
);

  logic [1:0] phase_ff; // System clock phase in instruction cycle
  logic [5:0] pre_ff;   // Prescaler count
  logic       inst;     // Last phase of an instruction cycle
  logic       go;       // Counting allowed

  assign inst = phase_ff == PH_LAST;
  assign go   = run_in && !hold_in;

  // Phase counter; frozen in sleep like the oscillator
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      phase_ff <= 2'h0;
    end else if (!hold_in) begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Prescaler; cleared while timer is off
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !run_in) begin
      pre_ff <= 6'h00;
    end else if (go && inst) begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  // Low bits from clock phase at 1:1, else from prescaler
  always_comb begin
    tick_out = '0;
    unique case (psel_in)
      PS_1: begin
        tick_out.step = go;
        tick_out.inc  = go && inst;
        tick_out.low2 = phase_ff;
      end
      PS_4: begin
        tick_out.step = go && inst;
        tick_out.inc  = go && inst && (&pre_ff[1:0]);
        tick_out.low2 = pre_ff[1:0];
      end
      PS_16: begin
        tick_out.step = go && inst && (&pre_ff[1:0]);
        tick_out.inc  = go && inst && (&pre_ff[3:0]);
        tick_out.low2 = pre_ff[3:2];
      end
      PS_64: begin
        tick_out.step = go && inst && (&pre_ff[3:0]);
        tick_out.inc  = go && inst && (&pre_ff);
        tick_out.low2 = pre_ff[5:4];
      end
    endcase
  end

endmodule
`default_nettype wire

// [tb.sv]
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench for the standard PWM unit
// ---------------------------------------------------------------
module tb
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clock_in;            // 50 MHz system clock
  logic        sys_rst_in;          // Sync reset, high
  logic        sleep_in;            // Sleep request
  logic [7:0]  avs_address_in;      // Bus address
  logic        avs_read_in;         // Bus read
  logic        avs_write_in;        // Bus write
  logic [31:0] avs_writedata_in;    // Bus write data
  logic [3:0]  avs_byteenable_in;   // Bus lanes
  logic [31:0] avs_readdata_out;    // Bus read data
  logic        avs_waitrequest_out; // Bus stall
  logic        pin_out;             // PWM level
  logic        pin_oe_out;          // Pin driver enable
  int          fails;               // Mismatch count
  int          checks_done;         // Comparison count
  int          cyc;                 // Cycle count for timeout

  cps_pwm dut (
    .clock_in            (clock_in),
    .sys_rst_in          (sys_rst_in),
    .sleep_in            (sleep_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .pin_out             (pin_out),
    .pin_oe_out          (pin_oe_out)
  );

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // Longest run is about 7.6k cycles; margin for slow answers
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One bus transfer: raised just after a rising edge, held until the
  // rising edge that samples waitrequest low; data taken at that edge
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clock_in);
    avs_address_in    <= a;
    avs_write_in      <= wr_en;
    avs_read_in       <= ~wr_en;
    avs_writedata_in  <= d;
    avs_byteenable_in <= be;
    // No answer time assumed; the hang guard ends a lost answer
    do begin
      @(posedge clock_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  // Register write with chosen lanes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  // Register read against an expected value
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, exp);
  endtask

  // Configure, let the duty buffer load, then count high cycles
  // over two whole periods, which makes the count phase-free
  task automatic run_case(input logic [7:0] plim, input logic [7:0] tctl,
                          input logic [7:0] ctrl, input logic [15:0] duty,
                          input int per, input int hi);
    int h;
    h = 0;
    wr(ADR_PLIM, {24'h00_0000, plim}, 4'hF);
    wr(ADR_CTRL, {24'h00_0000, ctrl}, 4'hF);
    wr(ADR_DUTY, {16'hFFFF, duty}, 4'h3);
    wr(ADR_TCTL, {24'h00_0000, tctl}, 4'hF);
    repeat (3 * per) @(posedge clock_in);
    repeat (2 * per) begin
      @(negedge clock_in);
      if (pin_out === 1'b1) h++;
    end
    chk(32'(h), 32'(2 * hi));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        p;
    int          k;
    sys_rst_in        = 1'b1;
    sleep_in          = 1'b0;
    avs_address_in    = 8'h00;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_writedata_in  = 32'h0000_0000;
    avs_byteenable_in = 4'h0;
    fails             = 0;
    checks_done       = 0;
    cyc               = 0;
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    // Reset state of pins and registers
    @(negedge clock_in);
    chk({31'h0, pin_oe_out}, 32'h0000_0000);
    rd(ADR_CTRL, 32'h0000_0000);
    rd(ADR_DUTY, 32'h0000_0000);
    rd(ADR_PLIM, 32'h0000_00FF);
    rd(ADR_TCTL, 32'h0000_0000);
    rd(ADR_TCNT, 32'h0000_0000);
    rd(ADR_PDIR, 32'h0000_0001);
    // Unmapped place ignores writes and reads zero
    wr(8'h1C, 32'hFFFF_FFFF, 4'hF);
    rd(8'h1C, 32'h0000_0000);
    // Driver enable follows the direction bit
    wr(ADR_PDIR, 32'h0000_0000, 4'hF);
    @(negedge clock_in);
    chk({31'h0, pin_oe_out}, 32'h0000_0001);
    // Short periods first, duty up to the whole period
    run_case(8'h00, 8'h80, 8'h8C, 16'h0002, 4, 2);
    run_case(8'h00, 8'h80, 8'h8C, 16'h0004, 4, 4);
    run_case(8'h03, 8'h80, 8'h8C, 16'hFC05, 16, 5);
    // Count never passes the limit while running
    for (k = 0; k < 8; k++) begin
      bus(1'b0, ADR_TCNT, 32'h0000_0000, 4'hF, q);
      chk(32'(q > 32'h3), 32'h0000_0000);
    end
    // Sleep freezes pin and count
    @(posedge clock_in);
    sleep_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    bus(1'b0, ADR_TCNT, 32'h0000_0000, 4'hF, q);
    @(negedge clock_in);
    p = pin_out;
    k = 0;
    repeat (40) begin
      @(negedge clock_in);
      if (pin_out !== p) k++;
    end
    chk(32'(k), 32'h0000_0000);
    rd(ADR_TCNT, q);
    @(posedge clock_in);
    sleep_in <= 1'b0;
    // Stopped timer: duty write must not reach the pin
    wr(ADR_TCTL, 32'h0000_0000, 4'hF);
    @(negedge clock_in);
    p = pin_out;
    wr(ADR_DUTY, 32'h0000_0000, 4'hF);
    repeat (20) @(posedge clock_in);
    @(negedge clock_in);
    chk({31'h0, pin_out}, {31'h0, p});
    // Flag set by earlier rollovers, cleared by writing one
    rd(ADR_STAT, 32'h0000_0001);
    wr(ADR_STAT, 32'h0000_0001, 4'hF);
    rd(ADR_STAT, 32'h0000_0000);
    // Postscaler and every prescale choice
    run_case(8'h03, 8'h8F, 8'h8C, 16'h0005, 16, 5);
    run_case(8'h03, 8'h90, 8'h8C, 16'h0005, 64, 20);
    run_case(8'h03, 8'hA0, 8'h8C, 16'h0005, 256, 80);
    run_case(8'h03, 8'hB0, 8'h8C, 16'h0005, 1024, 320);
    // Left alignment, zero duty, non-PWM mode, disabled unit
    run_case(8'h03, 8'h80, 8'h9C, 16'h01BF, 16, 6);
    run_case(8'h03, 8'h80, 8'h8C, 16'h0000, 16, 0);
    run_case(8'h03, 8'h80, 8'h88, 16'h0005, 16, 0);
    run_case(8'h03, 8'h80, 8'h0C, 16'h0005, 16, 0);
    // Second reset in mid-run
    run_case(8'h03, 8'h80, 8'h8C, 16'h0005, 16, 5);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    chk({30'h0, pin_out, pin_oe_out}, 32'h0000_0000);
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(ADR_CTRL, 32'h0000_0000);
    rd(ADR_PLIM, 32'h0000_00FF);
    rd(ADR_PDIR, 32'h0000_0001);
    final_report();
  end

endmodule
`default_nettype wire
